// [verilog/i2csb_slave.sv]
// i2csb_slave: slave end of the two-wire bus, all slave protocol in logic
// assumes the interface resolves the open-drain wires; user side is plain ports
//
// Summary of operation
// [RULE1] slave protocol in hardware, no general call
// [RULE2] start: SDA falls while SCL high
// [RULE3] stop: SDA rises while SCL high
// [RULE4] SDA changes only while SCL low
// [RULE5] both lines released when idle
// [RULE6] 7-bit address from upper seven bits
// [RULE7] 10-bit address: two bytes, 11110 prefix
// [RULE8] whole bytes, receiver acknowledges each byte
// [RULE9] no acknowledge: SDA released, master stops
// [RULE10] master nack ends slave transmit, SDA released
// [RULE11] stop during acknowledge ends transfer cleanly
// [RULE12] clock hold bit stretches SCL low
// [RULE13] repeated start begins new address phase
// [RULE14] losing master releases its SDA
// [RULE15] losing master clocks to byte end
// [RULE16] arbitration continues into data bytes
// [RULE17] losing master turns slave receiver; here the master end goes idle and releases SCL instead
// [RULE18] masters avoid arbitrating start or stop
// [RULE19] longest low period holds SCL low
// [RULE20] first finished high period pulls SCL low
// [RULE21] standard and fast rates interoperate
// [RULE22] no SPI mode exists here
// [RULE23] port works only while enabled
// [RULE24] SCL and SDA synchronised before use
`timescale 1ns/1ps
`default_nettype none
module i2csb_slave (
  input wire logic core_clk,
  input wire logic rst,
  i2csb_if.dev bus,
  input wire logic portEnable,
  input wire logic tenBitMode,
  input wire logic [9:0] ownAddress,
  input wire logic slaveClockHold,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic addressed,
  output logic readMode,
  output logic startSeen,
  output logic stopSeen
);
  import i2csb_pkg::*;
  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sclD;
    logic sdaS1;
    logic sdaS2;
    logic sdaD;
    i2csb_sst_t st;
    i2csb_kind_t kind;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic loaded;
    logic ackd;
    logic sdaLow;
    logic sclLow;
    logic addressed;
    logic readMode;
    logic tenHiOk;
    logic rxPush;
    logic [7:0] rxByte;
    logic startSeen;
    logic stopSeen;
  } i2csb_sstate_t;
  // synchronisers start at the idle-high bus level so no false stop follows reset
  localparam i2csb_sstate_t SLV_RST_ST = {6'h3f, 35'h0};
  i2csb_sstate_t cur_ff;
  i2csb_sstate_t nxt_cur;
  logic startEv;
  logic stopEv;
  logic sclRise;
  logic sclFall;
  logic match7;
  logic matchHi;
  logic accept;
  logic fifoInReady;

  // bus events from the second synchroniser stage onward
  assign startEv = cur_ff.sclS2 & cur_ff.sdaD & ~cur_ff.sdaS2; // RULE2
  assign stopEv = cur_ff.sclS2 & ~cur_ff.sdaD & cur_ff.sdaS2; // RULE3
  assign sclRise = cur_ff.sclS2 & ~cur_ff.sclD;
  assign sclFall = ~cur_ff.sclS2 & cur_ff.sclD;
  // address comparisons, bit 0 of the own address ignored in 7-bit form
  assign match7 = cur_ff.shift[7:1] == ownAddress[7:1]; // RULE1 RULE6
  assign matchHi = (cur_ff.shift[7:3] == ADDR10_MARK) && (cur_ff.shift[2:1] == ownAddress[9:8]); // RULE7

  // next-state logic
  always_comb begin
    nxt_cur = cur_ff;
    accept = 1'b0;
    txReady = 1'b0;
    nxt_cur.sclS1 = bus.scl; // RULE24
    nxt_cur.sclS2 = cur_ff.sclS1;
    nxt_cur.sclD = cur_ff.sclS2;
    nxt_cur.sdaS1 = bus.sda; // RULE24
    nxt_cur.sdaS2 = cur_ff.sdaS1;
    nxt_cur.sdaD = cur_ff.sdaS2;
    nxt_cur.rxPush = 1'b0;
    nxt_cur.startSeen = 1'b0;
    nxt_cur.stopSeen = 1'b0;
    if (!portEnable) begin
      // disabled port leaves the bus alone
      nxt_cur.st = S_IDLE; // RULE23
      nxt_cur.sdaLow = 1'b0;
      nxt_cur.addressed = 1'b0;
      nxt_cur.tenHiOk = 1'b0;
    end else if (startEv) begin
      // start or repeated start: fresh address phase
      nxt_cur.st = S_RXB; // RULE13
      nxt_cur.kind = K_ADDR;
      nxt_cur.bitCnt = 4'h0;
      nxt_cur.sdaLow = 1'b0;
      nxt_cur.addressed = 1'b0;
      nxt_cur.startSeen = 1'b1;
    end else if (stopEv) begin
      // stop ends any phase, also the acknowledge slot
      nxt_cur.st = S_IDLE; // RULE11
      nxt_cur.sdaLow = 1'b0; // RULE5
      nxt_cur.addressed = 1'b0;
      nxt_cur.tenHiOk = 1'b0;
      nxt_cur.stopSeen = 1'b1;
    end else begin
      case (cur_ff.st)
        S_RXB: begin
          // sample on rising SCL, decide after the eighth falling SCL
          if (sclRise) begin
            nxt_cur.shift = {cur_ff.shift[6:0], cur_ff.sdaS2};
            nxt_cur.bitCnt = cur_ff.bitCnt + 4'h1;
          end else if (sclFall && cur_ff.bitCnt == BYTE_BITS) begin
            case (cur_ff.kind)
              K_ADDR: begin
                nxt_cur.readMode = cur_ff.shift[0];
                nxt_cur.kind = K_DATA;
                if (tenBitMode) begin
                  // read form needs the full 10-bit match of an earlier write
                  accept = matchHi & (~cur_ff.shift[0] | cur_ff.tenHiOk); // RULE7
                  if (!cur_ff.shift[0]) begin
                    nxt_cur.kind = K_ADDR2;
                    nxt_cur.tenHiOk = 1'b0;
                  end
                end else begin
                  accept = match7; // RULE6
                end
              end
              K_ADDR2: begin
                accept = cur_ff.shift == ownAddress[7:0]; // RULE7
                nxt_cur.tenHiOk = accept;
                nxt_cur.kind = K_DATA;
              end
              default: begin
                // data byte kept only while the buffer has room
                accept = fifoInReady;
                nxt_cur.rxPush = fifoInReady;
                nxt_cur.rxByte = cur_ff.shift;
              end
            endcase
            if (accept) begin
              nxt_cur.st = S_ACK;
              nxt_cur.sdaLow = 1'b1; // RULE8
              nxt_cur.addressed = 1'b1;
            end else begin
              // not for us or no room: leave SDA high
              nxt_cur.st = S_IDLE; // RULE9
              nxt_cur.addressed = 1'b0;
            end
          end
        end
        S_ACK: begin
          // release after the acknowledge clock
          if (sclFall) begin
            nxt_cur.sdaLow = 1'b0; // RULE4
            nxt_cur.bitCnt = 4'h0;
            nxt_cur.loaded = 1'b0;
            nxt_cur.st = (cur_ff.readMode && cur_ff.kind == K_DATA) ? S_TXB : S_RXB;
          end
        end
        S_TXB: begin
          if (!cur_ff.loaded) begin
            // SCL is held low until the user gives a byte
            txReady = 1'b1;
            if (txValid) begin
              nxt_cur.shift = txData;
              nxt_cur.sdaLow = ~txData[7];
              nxt_cur.loaded = 1'b1;
            end
          end else if (sclFall) begin
            // next bit only while SCL is low
            nxt_cur.bitCnt = cur_ff.bitCnt + 4'h1; // RULE4
            if (cur_ff.bitCnt == BYTE_BITS - 4'h1) begin
              nxt_cur.st = S_TXACK;
              nxt_cur.sdaLow = 1'b0;
            end else begin
              nxt_cur.shift = {cur_ff.shift[6:0], 1'b0};
              nxt_cur.sdaLow = ~cur_ff.shift[6];
            end
          end
        end
        S_TXACK: begin
          // master acknowledge decides whether another byte follows
          if (sclRise) begin
            nxt_cur.ackd = ~cur_ff.sdaS2;
          end else if (sclFall) begin
            nxt_cur.loaded = 1'b0;
            nxt_cur.bitCnt = 4'h0;
            nxt_cur.st = cur_ff.ackd ? S_TXB : S_IDLE; // RULE10
            nxt_cur.addressed = cur_ff.ackd;
          end
        end
        default: begin
          // idle: wait for a start, SDA released; slaveClockHold can still hold a low SCL
          nxt_cur.sdaLow = 1'b0; // RULE5
        end
      endcase
    end
    // stretch only from a low SCL so no false edge appears
    nxt_cur.sclLow = portEnable & (slaveClockHold | (nxt_cur.st == S_TXB & ~nxt_cur.loaded))
                     & (cur_ff.sclLow | ~cur_ff.sclS2); // RULE12
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= SLV_RST_ST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // received bytes pass through the buffer
  i2csb_fifo #(
    .WIDTH(RX_FIFO_WIDTH),
    .DEPTH(RX_FIFO_DEPTH)
  ) rxFifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(cur_ff.rxPush),
    .inReady(fifoInReady),
    .inData(cur_ff.rxByte),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

  // open-drain pins: output always low, enable pulls
  assign bus.devSclOut = 1'b0;
  assign bus.devSdaOut = 1'b0;
  assign bus.devSclOe = cur_ff.sclLow;
  assign bus.devSdaOe = cur_ff.sdaLow;
  assign addressed = cur_ff.addressed;
  assign readMode = cur_ff.readMode;
  assign startSeen = cur_ff.startSeen;
  assign stopSeen = cur_ff.stopSeen;
endmodule
`default_nettype wire

// [verilog/i2csb_pkg.sv]
// i2csb_pkg: constants and types shared by both ends of the two-wire link
// assumes a 100 MHz core clock at each end
package i2csb_pkg;
  // core clock and fastest bus rate (400 Kbps)
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_MIN_PERIOD_NS = 2500;
  // half bus period in core cycles, rounded up so the rate never exceeds the limit
  localparam int SCL_HALF_CYC = (SCL_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] SCL_HALF_LAST = 8'(SCL_HALF_CYC - 1);
  // leading five bits that mark a 10-bit address byte
  localparam logic [4:0] ADDR10_MARK = 5'h1e;
  // received-data buffer
  localparam int RX_FIFO_WIDTH = 8;
  localparam int RX_FIFO_DEPTH = 16;
  // bits per byte, without the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // slave end states and byte kinds
  typedef enum logic [2:0] {S_IDLE, S_RXB, S_ACK, S_TXB, S_TXACK} i2csb_sst_t;
  typedef enum logic [1:0] {K_ADDR, K_ADDR2, K_DATA} i2csb_kind_t;
  // master end states and commands
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} i2csb_mst_t;
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} i2csb_cmd_t;
endpackage

// [verilog/i2csb_if.sv]
// i2csb_if: the two open-drain bus wires shared by the slave and master ends
// assumes external pull-ups: a wire is high unless some end pulls it low
`timescale 1ns/1ps
`default_nettype none
interface i2csb_if;
  logic devSclOut;
  logic devSclOe;
  logic devSdaOut;
  logic devSdaOe;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic scl;
  logic sda;
  // wired-and of all enabled drivers
  assign scl = ~((devSclOe & ~devSclOut) | (hostSclOe & ~hostSclOut));
  assign sda = ~((devSdaOe & ~devSdaOut) | (hostSdaOe & ~hostSdaOut));
  modport dev (input scl, input sda, output devSclOut, output devSclOe, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe);
endinterface
`default_nettype wire

// [verilog/i2csb_fifo.sv]
// i2csb_fifo: small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none
module i2csb_fifo #(
  parameter int WIDTH = i2csb_pkg::RX_FIFO_WIDTH,
  parameter int DEPTH = i2csb_pkg::RX_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  import i2csb_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } i2csb_fifo_t;
  i2csb_fifo_t cur_ff;
  i2csb_fifo_t nxt_cur;
  // pointers carry one wrap bit so full and empty differ
  always_comb begin
    nxt_cur = cur_ff;
    inReady = (cur_ff.wp ^ cur_ff.rp) != {1'b1, {AW{1'b0}}};
    outValid = cur_ff.wp != cur_ff.rp;
    outData = cur_ff.mem[cur_ff.rp[AW-1:0]];
    if (inValid && inReady) begin
      nxt_cur.mem[cur_ff.wp[AW-1:0]] = inData;
      nxt_cur.wp = cur_ff.wp + 1'b1;
    end
    if (outValid && outReady) begin
      nxt_cur.rp = cur_ff.rp + 1'b1;
    end
  end
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
endmodule
`default_nettype wire

// [verilog/i2csb_master.sv]
// i2csb_master: command-driven master end of the two-wire bus
// assumes one command at a time; SCL made here by a divider of core_clk
`timescale 1ns/1ps
`default_nettype none
module i2csb_master (
  input wire logic core_clk,
  input wire logic rst,
  i2csb_if.host bus,
  input wire logic cmdValid,
  input wire i2csb_pkg::i2csb_cmd_t cmd,
  input wire logic [7:0] cmdData,
  input wire logic rdAck,
  output logic cmdReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic nackSeen,
  output logic arbLost
);
  import i2csb_pkg::*;
  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sdaS1;
    logic sdaS2;
    i2csb_mst_t st;
    logic [1:0] step;
    logic [7:0] cnt;
    logic [3:0] bitCnt;
    logic [8:0] shift;
    logic reading;
    logic lost;
    logic sclLow;
    logic sdaLow;
    logic [7:0] rdData;
    logic rdValid;
    logic nack;
  } i2csb_mstate_t;
  i2csb_mstate_t cur_ff;
  i2csb_mstate_t nxt_cur;
  logic loDone;
  logic hiDone;

  // low phase is our own count; high phase ends early if another master pulls low
  assign loDone = cur_ff.cnt == SCL_HALF_LAST; // RULE21
  assign hiDone = loDone | (cur_ff.cnt != 8'h00 & ~cur_ff.sclS2); // RULE19 RULE20

  // next-state logic
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.sclS1 = bus.scl;
    nxt_cur.sclS2 = cur_ff.sclS1;
    nxt_cur.sdaS1 = bus.sda;
    nxt_cur.sdaS2 = cur_ff.sdaS1;
    nxt_cur.rdValid = 1'b0;
    nxt_cur.cnt = cur_ff.cnt + 8'h01;
    cmdReady = cur_ff.st == M_IDLE;
    if (cur_ff.st == M_IDLE || loDone || (cur_ff.step == 2'h1 && hiDone)) begin
      nxt_cur.cnt = 8'h00;
    end
    if (cur_ff.step == 2'h1 && !cur_ff.sclS2) begin
      // wait with SCL released until the wire really rises
      nxt_cur.cnt = 8'h00; // RULE20
    end
    case (cur_ff.st)
      M_START: begin
        // release SDA, raise SCL, then pull SDA low while SCL high
        case (cur_ff.step)
          2'h0: begin
            nxt_cur.sdaLow = 1'b0;
            if (loDone) nxt_cur.step = 2'h1;
          end
          2'h1: begin
            nxt_cur.sclLow = 1'b0;
            if (hiDone) nxt_cur.step = 2'h2;
          end
          default: begin
            nxt_cur.sdaLow = 1'b1; // RULE2
            if (loDone) begin
              nxt_cur.sclLow = 1'b1;
              nxt_cur.st = M_IDLE;
            end
          end
        endcase
      end
      M_STOP: begin
        // SDA low under low SCL, raise SCL, then release SDA
        case (cur_ff.step)
          2'h0: begin
            nxt_cur.sdaLow = 1'b1;
            if (loDone) nxt_cur.step = 2'h1;
          end
          2'h1: begin
            nxt_cur.sclLow = 1'b0;
            if (hiDone) nxt_cur.step = 2'h2;
          end
          default: begin
            nxt_cur.sdaLow = 1'b0; // RULE3 RULE5
            if (loDone) nxt_cur.st = M_IDLE;
          end
        endcase
      end
      M_BIT: begin
        if (cur_ff.step == 2'h0) begin
          // data set up only while SCL is low; a loser leaves SDA released
          nxt_cur.sclLow = 1'b1;
          nxt_cur.sdaLow = ~cur_ff.shift[8] & ~cur_ff.lost; // RULE4 RULE14
          if (loDone) nxt_cur.step = 2'h1;
        end else begin
          nxt_cur.sclLow = 1'b0;
          if (hiDone) begin
            nxt_cur.step = 2'h0;
            nxt_cur.shift = {cur_ff.shift[7:0], cur_ff.sdaS2};
            nxt_cur.bitCnt = cur_ff.bitCnt + 4'h1;
            // high sent, low seen: arbitration lost, on any written byte
            if (!cur_ff.reading && cur_ff.bitCnt < BYTE_BITS && cur_ff.shift[8] && !cur_ff.sdaS2) begin
              nxt_cur.lost = 1'b1; // RULE14 RULE16
            end
            if (cur_ff.bitCnt == BYTE_BITS) begin
              // byte and acknowledge done; a loser clocked to here, then lets go
              nxt_cur.st = M_IDLE; // RULE15 RULE17
              nxt_cur.sclLow = ~cur_ff.lost;
              nxt_cur.sdaLow = 1'b0;
              nxt_cur.nack = cur_ff.sdaS2; // RULE9
              nxt_cur.rdData = cur_ff.shift[7:0];
              nxt_cur.rdValid = cur_ff.reading;
            end
          end
        end
      end
      default: begin
        // accept one command; no arbitration on start or stop
        if (cmdValid) begin
          nxt_cur.step = 2'h0;
          nxt_cur.bitCnt = 4'h0;
          case (cmd)
            CMD_START: begin
              nxt_cur.st = M_START; // RULE13 RULE18
              nxt_cur.lost = 1'b0;
            end
            CMD_STOP: nxt_cur.st = M_STOP;
            CMD_WRITE: begin
              nxt_cur.st = M_BIT; // RULE8
              nxt_cur.reading = 1'b0;
              nxt_cur.shift = {cmdData, 1'b1};
            end
            default: begin
              // read one byte, acknowledged only when rdAck is set
              nxt_cur.st = M_BIT; // RULE10
              nxt_cur.reading = 1'b1;
              nxt_cur.shift = {8'hff, ~rdAck};
            end
          endcase
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // open-drain pins and status
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSclOe = cur_ff.sclLow;
  assign bus.hostSdaOe = cur_ff.sdaLow;
  assign rdData = cur_ff.rdData;
  assign rdValid = cur_ff.rdValid;
  assign nackSeen = cur_ff.nack;
  assign arbLost = cur_ff.lost;
endmodule
`default_nettype wire

// [bench/i2csb_chk.sv]
// i2csb_chk: wire-level checks on both ends of the two-wire bus
// assumes inputs tied to the shared interface signals, one core_clk domain
`timescale 1ns/1ps
`default_nettype none
module i2csb_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic devSclOut,
  input wire logic devSclOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic scl,
  input wire logic sda
);
  import i2csb_pkg::*;
  localparam int HI_MIN = SCL_HALF_CYC;
  typedef struct packed {logic sclQ; logic sdaQ; logic inFrame; logic [7:0] hiCnt;} i2csb_chkst_t;
  i2csb_chkst_t st_ff, nxt_st;
  // wire history, frame flag and saturating high-time count
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclQ = scl;
    nxt_st.sdaQ = sda;
    if (st_ff.sclQ && scl && st_ff.sdaQ && !sda) nxt_st.inFrame = 1'b1;
    else if (st_ff.sclQ && scl && !st_ff.sdaQ && sda) nxt_st.inFrame = 1'b0;
    if (!scl) nxt_st.hiCnt = 8'h00;
    else if (st_ff.hiCnt != 8'hff) nxt_st.hiCnt = st_ff.hiCnt + 8'h01;
  end
  // idle bus assumed at reset
  always_ff @(posedge core_clk) begin
    if (rst) st_ff <= '{sclQ: 1'b1, sdaQ: 1'b1, inFrame: 1'b0, hiCnt: 8'hff};
    else st_ff <= nxt_st;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_start; st_ff.sclQ && scl && st_ff.sdaQ && !sda; endsequence
  sequence s_stop; st_ff.sclQ && scl && !st_ff.sdaQ && sda; endsequence
  sequence s_released; (!devSdaOe && !devSclOe && !hostSdaOe && !hostSclOe) [*8]; endsequence
  property p_devSdaLow; $changed(devSdaOe) |-> !scl && !$past(scl); endproperty
  property p_syncDelay; $fell(scl) |=> $stable(devSdaOe) [*2]; endproperty
  property p_startClock; s_start |-> ##[1:300] hostSclOe; endproperty
  property p_stopByHost; s_stop |-> !devSdaOe && $past(hostSdaOe); endproperty
  property p_idle; s_stop |=> s_released; endproperty
  property p_holdLow; $rose(devSclOe) |-> !scl && !$past(scl); endproperty
  property p_frameOnly; devSdaOe || devSclOe |-> st_ff.inFrame; endproperty
  property p_rate; $fell(scl) |-> st_ff.hiCnt >= HI_MIN; endproperty
  property p_openDrain; !devSclOut && !devSdaOut && !hostSclOut && !hostSdaOut; endproperty
  a_devSdaLow: assert property (p_devSdaLow)
    else $error("slave data changed while clock high");
  a_syncDelay: assert property (p_syncDelay)
    else $error("slave reacted before clock fall was synchronised");
  a_startClock: assert property (p_startClock)
    else $error("no clock low after start");
  a_stopByHost: assert property (p_stopByHost)
    else $error("stop not made by master release");
  a_idle: assert property (p_idle)
    else $error("line driven after stop");
  a_holdLow: assert property (p_holdLow)
    else $error("clock hold taken while clock high");
  a_frameOnly: assert property (p_frameOnly)
    else $error("slave drove bus outside a frame");
  a_rate: assert property (p_rate)
    else $error("clock high period too short");
  a_openDrain: assert property (p_openDrain)
    else $error("pin driven high instead of released");
endmodule
`default_nettype wire

// [bench/i2c_slave_bus_protocol_tb_top.sv]
// i2c_slave_bus_protocol_tb_top: self-checking bench, master end drives slave end
// assumes 100 MHz core clock; both ends share one bus interface
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_bus_protocol_tb_top;
  import i2csb_pkg::*;
  logic core_clk, rst, portEnable, tenBitMode, slaveClockHold, rxValid, rxReady, txValid, txReady;
  logic addressed, readMode, startSeen, stopSeen, cmdValid, rdAck, cmdReady, rdValid, nackSeen, arbLost;
  logic [9:0] ownAddress;
  logic [7:0] rxData, txData, cmdData, rdData;
  i2csb_cmd_t cmd;
  int badCount, totalChecks, startCnt, stopCnt, rdCnt, txPtr;
  logic [7:0] txTab [4] = '{8'h5a, 8'hc3, 8'h0f, 8'h96};
  i2csb_if i2csb_if_i ();
  i2csb_slave i2csb_slave_i (.core_clk(core_clk), .rst(rst), .bus(i2csb_if_i.dev), .portEnable(portEnable),
    .tenBitMode(tenBitMode), .ownAddress(ownAddress), .slaveClockHold(slaveClockHold), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
    .addressed(addressed), .readMode(readMode), .startSeen(startSeen), .stopSeen(stopSeen));
  i2csb_master i2csb_master_i (.core_clk(core_clk), .rst(rst), .bus(i2csb_if_i.host), .cmdValid(cmdValid),
    .cmd(cmd), .cmdData(cmdData), .rdAck(rdAck), .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid),
    .nackSeen(nackSeen), .arbLost(arbLost));
  i2csb_chk i2csb_chk_i (.core_clk(core_clk), .rst(rst), .devSclOut(i2csb_if_i.devSclOut),
    .devSclOe(i2csb_if_i.devSclOe), .devSdaOut(i2csb_if_i.devSdaOut), .devSdaOe(i2csb_if_i.devSdaOe),
    .hostSclOut(i2csb_if_i.hostSclOut), .hostSclOe(i2csb_if_i.hostSclOe), .hostSdaOut(i2csb_if_i.hostSdaOut),
    .hostSdaOe(i2csb_if_i.hostSdaOe), .scl(i2csb_if_i.scl), .sda(i2csb_if_i.sda));
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // pulse counters and transmit byte feeder
  assign txData = txTab[2'(txPtr)];
  always @(posedge core_clk) begin
    if (startSeen === 1'b1) startCnt <= startCnt + 1;
    if (stopSeen === 1'b1) stopCnt <= stopCnt + 1;
    if (rdValid === 1'b1) rdCnt <= rdCnt + 1;
    if (txValid && txReady === 1'b1) txPtr <= txPtr + 1;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    totalChecks++;
    if (s !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one master command: hold until taken, then wait for completion
  task automatic mcmd(input i2csb_cmd_t c, input logic [7:0] d, input logic a);
    int n;
    logic r;
    n = 0;
    cmdValid <= 1'b1;
    cmd <= c;
    cmdData <= d;
    rdAck <= a;
    do begin
      @(negedge core_clk);
      r = cmdReady;
      @(posedge core_clk);
    end while (r !== 1'b1);
    cmdValid <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 9000);
    if (n >= 9000) chk("cmdReady", 8'h01, 8'h00);
    @(posedge core_clk);
  endtask
  task automatic mstop;
    mcmd(CMD_STOP, 8'h00, 1'b0);
    repeat (20) @(posedge core_clk);
  endtask
  task automatic wrb(input logic [7:0] d, input logic nk);
    mcmd(CMD_WRITE, d, 1'b0);
    chk("nackSeen", 8'(nk), 8'(nackSeen));
  endtask
  task automatic drain(input int n, input logic [7:0] base);
    rxReady <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      chk("rxValid", 8'h01, 8'(rxValid));
      chk("rxData", base + 8'(i), rxData);
      @(posedge core_clk);
    end
    rxReady <= 1'b0;
    @(negedge core_clk);
    chk("rxValid", 8'h00, 8'(rxValid));
    @(posedge core_clk);
  endtask
  task automatic t_write7;
    int s0;
    int p0;
    s0 = startCnt;
    p0 = stopCnt;
    tenBitMode <= 1'b0;
    ownAddress <= 10'h0a5;
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'ha4, 1'b0);
    wrb(8'h3c, 1'b0);
    chk("addressed", 8'h01, 8'(addressed));
    chk("readMode", 8'h00, 8'(readMode));
    chk("arbLost", 8'h00, 8'(arbLost));
    mstop();
    drain(1, 8'h3c);
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'ha6, 1'b1);
    mstop();
    chk("startSeen", 8'h02, 8'(startCnt - s0));
    chk("stopSeen", 8'h02, 8'(stopCnt - p0));
    $display("test write7 done");
  endtask
  task automatic t_read7;
    int r0;
    r0 = rdCnt;
    txValid <= 1'b1;
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'ha5, 1'b0);
    chk("readMode", 8'h01, 8'(readMode));
    mcmd(CMD_READ, 8'h00, 1'b1);
    chk("rdData", 8'h5a, rdData);
    mcmd(CMD_READ, 8'h00, 1'b0);
    chk("rdData", 8'hc3, rdData);
    mstop();
    chk("rdValid", 8'h02, 8'(rdCnt - r0));
    $display("test read7 done");
  endtask
  task automatic t_tenbit;
    int s0;
    tenBitMode <= 1'b1;
    ownAddress <= 10'h2b6;
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'hf4, 1'b0);
    wrb(8'hb6, 1'b0);
    wrb(8'h77, 1'b0);
    s0 = startCnt;
    mcmd(CMD_START, 8'h00, 1'b0);
    chk("startSeen", 8'h01, 8'(startCnt - s0));
    wrb(8'hf5, 1'b0);
    chk("readMode", 8'h01, 8'(readMode));
    mcmd(CMD_READ, 8'h00, 1'b0);
    chk("rdData", 8'h0f, rdData);
    mstop();
    drain(1, 8'h77);
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'hf6, 1'b1);
    mstop();
    txValid <= 1'b0;
    tenBitMode <= 1'b0;
    ownAddress <= 10'h0a5;
    $display("test tenbit done");
  endtask
  task automatic t_fifo;
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'ha4, 1'b0);
    for (int i = 0; i < 17; i++) wrb(8'h10 + 8'(i), 1'(i == 16));
    mstop();
    drain(16, 8'h10);
    $display("test fifo done");
  endtask
  task automatic t_hold;
    mcmd(CMD_START, 8'h00, 1'b0);
    slaveClockHold <= 1'b1;
    fork
      wrb(8'ha4, 1'b0);
      begin
        repeat (3000) @(posedge core_clk);
        chk("scl", 8'h00, 8'(i2csb_if_i.scl));
        chk("cmdReady", 8'h00, 8'(cmdReady));
        slaveClockHold <= 1'b0;
      end
    join
    mstop();
    $display("test hold done");
  endtask
  task automatic t_enable;
    int s0;
    int p0;
    portEnable <= 1'b0;
    s0 = startCnt;
    p0 = stopCnt;
    mcmd(CMD_START, 8'h00, 1'b0);
    wrb(8'ha4, 1'b1);
    mstop();
    chk("startSeen", 8'h00, 8'(startCnt - s0));
    chk("stopSeen", 8'h00, 8'(stopCnt - p0));
    portEnable <= 1'b1;
    $display("test enable done");
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    portEnable = 1'b1;
    tenBitMode = 1'b0;
    ownAddress = 10'h0a5;
    slaveClockHold = 1'b0;
    rxReady = 1'b0;
    txValid = 1'b0;
    cmdValid = 1'b0;
    cmd = CMD_START;
    cmdData = 8'h00;
    rdAck = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    t_write7();
    t_read7();
    t_tenbit();
    t_fifo();
    t_hold();
    t_enable();
    stopTest();
  end
  // watchdog sized a little above the expected run
  initial begin
    repeat (95000) @(posedge core_clk);
    badCount++;
    stopTest();
  end
endmodule
`default_nettype wire
